// file: shared/drc_pkg.sv
// Constants, types and helpers for the DRAM controller reset, programming
// and initialization block.
// Assumes a 125 MHz system clock and a classic Wishbone register bus.
//
// Overview of operation
// - System clock runs the arbiter and times refresh RAS low and precharge.
// - Acknowledge is held and released on rising system clock edges.
// - Delay-line clock is sampled, so it must run below half the system clock rate.
// - Delay-line clock divided by 6..20 in steps of two gives the reference.
// - Refresh request clock is the reference further divided down.
// - Reset pin acts asynchronously; host holds it for 16 clock edges.
// - First programming after reset starts one initialization period only.
// - During initialization refresh indicator held, RAS pulses every 13 or 15 us.
// - During initialization CAS stays negated while row address steps 0..2047.
// - Initialization lasts 4096 refresh clock periods.
// - Mode-load only: bits latched when the mode-load strobe is negated.
// - On that request, wait bits apply and acknowledge asserts on the same clock edge.
// - On strobe negation after that access, remaining bits apply.

package drc_pkg;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 8;
   localparam int REF_MHZ        = 2;
   localparam int RFSH_SHORT_US  = 13;
   localparam int RFSH_LONG_US   = 15;
   localparam int RAS_LOW_NS     = 100;
   localparam int PRECHARGE_NS   = 80;
   localparam int INIT_TICKS     = 4096;

   function automatic int cycles_min(input int ns);
      return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   endfunction

   localparam int RAS_LOW_CYC    = cycles_min(RAS_LOW_NS);
   localparam int PRECHARGE_CYC  = cycles_min(PRECHARGE_NS);

   // -----------------------------------------------------------------
   // Programming word layout
   // -----------------------------------------------------------------
   localparam int ADDR_W         = 22;
   localparam int ROW_W          = 11;
   localparam int DIV_LSB        = 0;
   localparam int DIV_W          = 3;
   localparam int RFSH_BIT       = 3;
   localparam int WAIT_LSB       = 4;
   localparam int WAIT_W         = 3;
   localparam int DIV_BASE       = 3;
   localparam int TUNE_W         = 8;

   typedef struct packed {
      logic              extend_cas_in0;
      logic              bank1;
      logic              bank0;
      logic [ADDR_W-1:0] addr;
   } drc_prog_t;

   localparam drc_prog_t PROG_RST = '0;

   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_PROG   = 8'h04;
   localparam logic [7:0] REG_TUNE   = 8'h08;

   localparam logic [TUNE_W-1:0] TUNE_SHORT_RST = TUNE_W'(RFSH_SHORT_US * REF_MHZ);
   localparam logic [TUNE_W-1:0] TUNE_LONG_RST  = TUNE_W'(RFSH_LONG_US * REF_MHZ);

   localparam int ST_PROG_BIT    = 0;
   localparam int ST_INIT_BIT    = 1;
   localparam int ST_REFRESH_IN_PROGRESS_N_BIT    = 2;
   localparam int ST_CSP_BIT     = 3;
   localparam int ST_ROW_LSB     = 16;

   // -----------------------------------------------------------------
   // Arbiter states
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      ARB_IDLE = 2'b00,
      ARB_RAS  = 2'b01,
      ARB_PRE  = 2'b10,
      ARB_ACK  = 2'b11
   } drc_arb_t;

endpackage

// file: rtl/drc_clk_div.sv
// Delay-line clock divider: 2 MHz reference and refresh request ticks.
// Assumes the delay-line clock input is sampled on the system clock.
`timescale 1ns/1ps
`default_nettype none

module drc_clk_div
   import drc_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              dl_clk_i,
   input  wire logic [DIV_W-1:0]  div_sel_i,
   input  wire logic [TUNE_W-1:0] tune_i,
   output logic                   ref_o,
   output logic                   tick_o
);

   logic              dl_q;
   logic [4:0]        half_q;
   logic [TUNE_W-1:0] tune_q;
   logic              ref_q;
   logic              tick_q;
   logic              dl_rise;
   logic [4:0]        half_max;

   assign dl_rise  = dl_clk_i & ~dl_q;
   assign half_max = 5'(div_sel_i) + 5'(DIV_BASE - 1);
   assign ref_o    = ref_q;
   assign tick_o   = tick_q;

   // -----------------------------------------------------------------
   // Reference divider
   // -----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dl_q   <= 1'b0;
         half_q <= '0;
         ref_q  <= 1'b0;
      end else begin
         dl_q <= dl_clk_i;
         if (dl_rise) begin
            if (half_q >= half_max) begin
               half_q <= '0;
               ref_q  <= ~ref_q;
            end else begin
               half_q <= half_q + 5'd1;
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // Refresh clock
   // -----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tune_q <= '0;
         tick_q <= 1'b0;
      end else begin
         tick_q <= 1'b0;
         if (dl_rise && half_q >= half_max && !ref_q) begin
            if (tune_q >= tune_i - TUNE_W'(1)) begin
               tune_q <= '0;
               tick_q <= 1'b1;
            end else begin
               tune_q <= tune_q + TUNE_W'(1);
            end
         end
      end
   end

endmodule

`default_nettype wire

// file: rtl/drc_prog_reset_init.sv
// DRAM controller reset, programming and power-up initialization.
// Assumes host pins synchronous to clk_i and a classic Wishbone master.
//
// Design decisions made here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module drc_prog_reset_init
   import drc_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              ctrl_reset_n_i,
   // Wishbone slave
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [7:0]        wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic [31:0]            wb_dat_o,
   output logic                   wb_ack_o,
   // Host programming pins
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic              bank_sel_in0_i,
   input  wire logic              bank_sel_in1_i,
   input  wire logic              extend_cas_in0_i,
   input  wire logic              mode_load_strobe_n_i,
   input  wire logic              chip_select_n_i,
   input  wire logic              access_request_n_i,
   input  wire logic              delay_line_clock_in_i,
   output logic                   transfer_acknowledge_n_o,
   // DRAM side
   output logic                   refresh_in_progress_n_o,
   output logic                   ras_n_o,
   output logic                   cas_n_o,
   output logic [ROW_W-1:0]       refresh_addr_o,
   output logic                   dl_ref_o,
   output logic [WAIT_W-1:0]      wait_bits_o
);

   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   drc_arb_t          state_q;
   drc_arb_t          state_d;
   drc_prog_t         prog_q;
   drc_prog_t         pend_q;
   drc_prog_t         pin_word;
   logic [WAIT_W-1:0] wait_q;
   logic              programmed_q;
   logic              init_q;
   logic              cs_prog_q;
   logic              ml_q;
   logic              access_request_n_q;
   logic              rf_pend_q;
   logic [12:0]       init_cnt_q;
   logic [ROW_W-1:0]  row_q;
   logic [7:0]        cyc_q;
   logic [TUNE_W-1:0] tune_short_q;
   logic [TUNE_W-1:0] tune_long_q;
   logic              ack_q;
   logic [31:0]       rdat_q;
   logic              ras_n_q;
   logic              ack_n_q;
   logic              ml_rise;
   logic              access_request_n_fall;
   logic              cs_take;
   logic              tick;
   logic              div_rst;
   logic              rf_enter;
   logic              rf_done;
   logic [TUNE_W-1:0] tune_sel;
   logic              wb_req;
   logic              wb_wr;

   assign pin_word.extend_cas_in0 = extend_cas_in0_i;
   assign pin_word.bank1 = bank_sel_in1_i;
   assign pin_word.bank0 = bank_sel_in0_i;
   assign pin_word.addr  = addr_i;

   // -----------------------------------------------------------------
   // Pin edge detection
   // -----------------------------------------------------------------
   assign ml_rise   = mode_load_strobe_n_i & ~ml_q;
   assign access_request_n_fall = ~access_request_n_i & access_request_n_q;
   assign cs_take   = access_request_n_fall & ~mode_load_strobe_n_i
                      & ~chip_select_n_i & (state_q == ARB_IDLE);

   always_ff @(posedge clk_i or negedge ctrl_reset_n_i) begin
      if (!ctrl_reset_n_i) begin
         ml_q   <= 1'b1;
         access_request_n_q <= 1'b1;
      end else if (rst_i) begin
         ml_q   <= 1'b1;
         access_request_n_q <= 1'b1;
      end else begin
         ml_q   <= mode_load_strobe_n_i;
         access_request_n_q <= access_request_n_i;
      end
   end

   // -----------------------------------------------------------------
   // Programming register
   // -----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge ctrl_reset_n_i) begin
      if (!ctrl_reset_n_i) begin
         prog_q    <= PROG_RST;
         pend_q    <= PROG_RST;
         wait_q    <= '0;
         cs_prog_q <= 1'b0;
      end else if (rst_i) begin
         prog_q    <= PROG_RST;
         pend_q    <= PROG_RST;
         wait_q    <= '0;
         cs_prog_q <= 1'b0;
      end else begin
         if (cs_take) begin
            pend_q    <= pin_word;
            cs_prog_q <= 1'b1;
            wait_q    <= addr_i[WAIT_LSB +: WAIT_W];
         end else if (ml_rise) begin
            if (cs_prog_q) begin
               prog_q    <= pend_q;
               cs_prog_q <= 1'b0;
            end else begin
               prog_q <= pin_word;
               wait_q <= addr_i[WAIT_LSB +: WAIT_W];
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // Initialization period
   // -----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge ctrl_reset_n_i) begin
      if (!ctrl_reset_n_i) begin
         programmed_q <= 1'b0;
         init_q       <= 1'b0;
         init_cnt_q   <= '0;
      end else if (rst_i) begin
         programmed_q <= 1'b0;
         init_q       <= 1'b0;
         init_cnt_q   <= '0;
      end else begin
         if (ml_rise) begin
            programmed_q <= 1'b1;
            if (!programmed_q) begin
               init_q     <= 1'b1;
               init_cnt_q <= '0;
            end
         end else if (init_q && rf_done) begin
            if (init_cnt_q == 13'(INIT_TICKS - 1)) begin
               init_q <= 1'b0;
            end else begin
               init_cnt_q <= init_cnt_q + 13'd1;
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // Refresh request and row counter
   // -----------------------------------------------------------------
   assign tune_sel = prog_q.addr[RFSH_BIT] ? tune_long_q : tune_short_q;
   assign div_rst  = rst_i | ~programmed_q;

   drc_clk_div u_div (
      .clk_i     (clk_i),
      .rst_i     (div_rst),
      .dl_clk_i  (delay_line_clock_in_i),
      .div_sel_i (prog_q.addr[DIV_LSB +: DIV_W]),
      .tune_i    (tune_sel),
      .ref_o     (dl_ref_o),
      .tick_o    (tick)
   );

   always_ff @(posedge clk_i or negedge ctrl_reset_n_i) begin
      if (!ctrl_reset_n_i) begin
         rf_pend_q <= 1'b0;
         row_q     <= '0;
      end else if (rst_i) begin
         rf_pend_q <= 1'b0;
         row_q     <= '0;
      end else begin
         if (tick && (init_q || !prog_q.extend_cas_in0)) begin
            rf_pend_q <= 1'b1;
         end else if (rf_enter) begin
            rf_pend_q <= 1'b0;
         end
         if (ml_rise && !programmed_q) begin
            row_q <= '0;
         end else if (rf_done) begin
            row_q <= row_q + ROW_W'(1);
         end
      end
   end

   // -----------------------------------------------------------------
   // Arbiter
   // -----------------------------------------------------------------
   assign rf_enter = (state_q == ARB_IDLE) & rf_pend_q & ~cs_take;
   assign rf_done  = (state_q == ARB_PRE) & (cyc_q == 8'd0);

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ARB_IDLE: begin
            if (cs_take) begin
               state_d = ARB_ACK;
            end else if (rf_pend_q) begin
               state_d = ARB_RAS;
            end
         end
         ARB_RAS: begin
            if (cyc_q == 8'd0) begin
               state_d = ARB_PRE;
            end
         end
         ARB_PRE: begin
            if (cyc_q == 8'd0) begin
               state_d = ARB_IDLE;
            end
         end
         ARB_ACK: begin
            if (access_request_n_i) begin
               state_d = ARB_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge ctrl_reset_n_i) begin
      if (!ctrl_reset_n_i) begin
         state_q <= ARB_IDLE;
      end else if (rst_i) begin
         state_q <= ARB_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clk_i or negedge ctrl_reset_n_i) begin
      if (!ctrl_reset_n_i) begin
         cyc_q <= '0;
      end else if (rst_i) begin
         cyc_q <= '0;
      end else if (state_q == ARB_IDLE && state_d == ARB_RAS) begin
         cyc_q <= 8'(RAS_LOW_CYC - 1);
      end else if (state_q == ARB_RAS && state_d == ARB_PRE) begin
         cyc_q <= 8'(PRECHARGE_CYC - 1);
      end else if (cyc_q != 8'd0) begin
         cyc_q <= cyc_q - 8'd1;
      end
   end

   // -----------------------------------------------------------------
   // DRAM and host outputs
   // -----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge ctrl_reset_n_i) begin
      if (!ctrl_reset_n_i) begin
         ras_n_q <= 1'b1;
         ack_n_q <= 1'b1;
      end else if (rst_i) begin
         ras_n_q <= 1'b1;
         ack_n_q <= 1'b1;
      end else begin
         ras_n_q <= ~(state_d == ARB_RAS);
         ack_n_q <= ~(state_d == ARB_ACK);
      end
   end

   assign ras_n_o                  = ras_n_q;
   assign cas_n_o                  = 1'b1;
   assign refresh_addr_o           = row_q;
   assign transfer_acknowledge_n_o = ack_n_q;
   assign wait_bits_o              = wait_q;
   assign refresh_in_progress_n_o  = ~(init_q | (state_q == ARB_RAS)
                                       | (state_q == ARB_PRE));

   // -----------------------------------------------------------------
   // Wishbone slave
   // -----------------------------------------------------------------
   assign wb_req   = wb_cyc_i & wb_stb_i & ~ack_q;
   assign wb_wr    = wb_req & wb_we_i;
   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q  <= 1'b0;
         rdat_q <= '0;
      end else begin
         ack_q  <= wb_req;
         rdat_q <= '0;
         if (wb_req && !wb_we_i) begin
            unique case (wb_adr_i)
               REG_STATUS: begin
                  rdat_q[ST_PROG_BIT]             <= programmed_q;
                  rdat_q[ST_INIT_BIT]             <= init_q;
                  rdat_q[ST_REFRESH_IN_PROGRESS_N_BIT]             <= ~refresh_in_progress_n_o;
                  rdat_q[ST_CSP_BIT]              <= cs_prog_q;
                  rdat_q[ST_ROW_LSB +: ROW_W]     <= row_q;
               end
               REG_PROG: begin
                  rdat_q[$bits(drc_prog_t)-1:0]   <= prog_q;
               end
               REG_TUNE: begin
                  rdat_q[TUNE_W-1:0]              <= tune_short_q;
                  rdat_q[2*TUNE_W-1:TUNE_W]       <= tune_long_q;
               end
               default: begin
                  rdat_q <= '0;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tune_short_q <= TUNE_SHORT_RST;
         tune_long_q  <= TUNE_LONG_RST;
      end else if (wb_wr && wb_adr_i == REG_TUNE) begin
         if (wb_sel_i[0]) begin
            tune_short_q <= wb_dat_i[TUNE_W-1:0];
         end
         if (wb_sel_i[1]) begin
            tune_long_q <= wb_dat_i[2*TUNE_W-1:TUNE_W];
         end
      end
   end

endmodule

`default_nettype wire

// file: test/drc_far_model.sv
// Far-side model: delay-line clock source and DRAM array watcher.
// Assumes the system clock is the single reference for the bench.
`timescale 1ns/1ps
`default_nettype none

module drc_far_model (
   input  wire logic clk_i,
   input  wire logic ras_n_i,
   input  wire logic cas_n_i,
   output logic      dl_clk_o,
   output logic      cas_err_o
);
   logic ph_q = 1'b0;

   initial dl_clk_o = 1'b0;
   initial cas_err_o = 1'b0;

   // Delay-line clock at a quarter of the system clock, same source
   always @(posedge clk_i) begin
      ph_q <= !ph_q;
      if (ph_q) begin
         dl_clk_o <= !dl_clk_o;
      end
   end

   // Array flags CAS during a refresh row strobe
   always @(posedge clk_i) begin
      if (!cas_n_i && !ras_n_i) begin
         cas_err_o <= 1'b1;
      end
   end
endmodule

`default_nettype wire

// file: test/drc_prog_reset_init_assertions.sv
// Checker for the programming, reset and init block.
// Bound to the block's top module; sees its ports only.
`timescale 1ns/1ps
`default_nettype none

module drc_sva_chk
   import drc_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              ctrl_reset_n_i,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_ack_o,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic              mode_load_strobe_n_i,
   input  wire logic              chip_select_n_i,
   input  wire logic              access_request_n_i,
   input  wire logic              transfer_acknowledge_n_o,
   input  wire logic              refresh_in_progress_n_o,
   input  wire logic              ras_n_o,
   input  wire logic              cas_n_o,
   input  wire logic [ROW_W-1:0]  refresh_addr_o,
   input  wire logic [WAIT_W-1:0] wait_bits_o
);
   logic [7:0] ras_low_q;

   // Length of the current row strobe
   always_ff @(posedge clk_i) begin
      if (rst_i || ras_n_o) begin
         ras_low_q <= 8'h00;
      end else begin
         ras_low_q <= ras_low_q + 8'h01;
      end
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_cs_take;
      $fell(access_request_n_i) && !mode_load_strobe_n_i && !chip_select_n_i
         && refresh_in_progress_n_o && ras_n_o && transfer_acknowledge_n_o;
   endsequence
   sequence s_cs_answer;
      !transfer_acknowledge_n_o && wait_bits_o == addr_i[WAIT_LSB +: WAIT_W];
   endsequence

   property p_cas_idle;
      cas_n_o;
   endproperty
   property p_ras_flag;
      !ras_n_o |-> !refresh_in_progress_n_o;
   endproperty
   property p_ras_len;
      ctrl_reset_n_i && $rose(ras_n_o) |-> ras_low_q == RAS_LOW_CYC;
   endproperty
   property p_row_step;
      ctrl_reset_n_i && $past(ctrl_reset_n_i) && $changed(refresh_addr_o)
         |-> refresh_addr_o == $past(refresh_addr_o) + 11'h001;
   endproperty
   property p_reset_quiet;
      !ctrl_reset_n_i |-> ras_n_o && refresh_in_progress_n_o && transfer_acknowledge_n_o;
   endproperty
   property p_ml_load;
      $rose(mode_load_strobe_n_i) |-> ##[1:3] wait_bits_o == addr_i[WAIT_LSB +: WAIT_W];
   endproperty
   property p_cs_ack;
      s_cs_take |=> s_cs_answer;
   endproperty
   property p_ack_hold;
      !transfer_acknowledge_n_o && !access_request_n_i |=> !transfer_acknowledge_n_o;
   endproperty
   property p_ack_end;
      !transfer_acknowledge_n_o && access_request_n_i |=> transfer_acknowledge_n_o;
   endproperty
   property p_wb_ack;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
   endproperty

   a_cas_idle: assert property (p_cas_idle) else $error("cas asserted");
   a_ras_flag: assert property (p_ras_flag) else $error("ras low without flag");
   a_ras_len: assert property (p_ras_len) else $error("ras low time wrong");
   a_row_step: assert property (p_row_step) else $error("row skipped");
   a_reset_quiet: assert property (p_reset_quiet) else $error("busy in reset");
   a_ml_load: assert property (p_ml_load) else $error("strobe load missed");
   a_cs_ack: assert property (p_cs_ack) else $error("select access not answered");
   a_ack_hold: assert property (p_ack_hold) else $error("ack dropped early");
   a_ack_end: assert property (p_ack_end) else $error("ack held late");
   a_wb_ack: assert property (p_wb_ack) else $error("bus ack wrong");
endmodule

bind drc_prog_reset_init drc_sva_chk u_drc_sva_chk (.clk_i, .rst_i, .ctrl_reset_n_i, .wb_cyc_i, .wb_stb_i,
   .wb_ack_o, .addr_i, .mode_load_strobe_n_i, .chip_select_n_i, .access_request_n_i,
   .transfer_acknowledge_n_o, .refresh_in_progress_n_o, .ras_n_o, .cas_n_o, .refresh_addr_o, .wait_bits_o);

`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the programming, reset and init block.
// Host pins and bus driven here; far side from drc_far_model.
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import drc_pkg::*;

   logic              clk_i = 1'b0;
   logic              rst_i = 1'b1;
   logic              rst_n = 1'b0;
   logic              cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]        adr = 8'h00;
   logic [31:0]       wdat = 32'h0, rdat;
   logic              ack, dl_clk, transfer_acknowledge_n_n, refresh_in_progress_n_n, ras_n, cas_n, dlref, cas_err;
   logic [ADDR_W-1:0] addr = 22'h000000;
   logic              bk0 = 1'b0, bk1 = 1'b0, ecas = 1'b0;
   logic              ml_n = 1'b1, cs_n = 1'b1, access_request_n_n = 1'b1;
   logic [ROW_W-1:0]  row;
   logic [WAIT_W-1:0] wbits;
   int                fails = 0, n_checks = 0;

   initial forever #4 clk_i = ~clk_i;

   drc_prog_reset_init u_drc_prog_reset_init (.clk_i(clk_i), .rst_i(rst_i), .ctrl_reset_n_i(rst_n),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .addr_i(addr), .bank_sel_in0_i(bk0), .bank_sel_in1_i(bk1),
      .extend_cas_in0_i(ecas), .mode_load_strobe_n_i(ml_n), .chip_select_n_i(cs_n),
      .access_request_n_i(access_request_n_n), .delay_line_clock_in_i(dl_clk), .transfer_acknowledge_n_o(transfer_acknowledge_n_n),
      .refresh_in_progress_n_o(refresh_in_progress_n_n), .ras_n_o(ras_n), .cas_n_o(cas_n), .refresh_addr_o(row),
      .dl_ref_o(dlref), .wait_bits_o(wbits));

   drc_far_model u_drc_far_model (.clk_i(clk_i), .ras_n_i(ras_n), .cas_n_i(cas_n), .dl_clk_o(dl_clk),
      .cas_err_o(cas_err));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic step(inout int i);
      @(posedge clk_i);
      i++;
      if (i > 600) begin
         fails++;
         report_and_stop();
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int i;
      i = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do step(i); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic do_reset();
      int i;
      i = 0;
      rst_n <= 1'b0;
      repeat (16) step(i);
      rst_n <= 1'b1;
      chk({ras_n, refresh_in_progress_n_n, transfer_acknowledge_n_n, wbits, row}, {3'b111, 3'h0, 11'h000});
   endtask

   task automatic t_regs();
      logic [31:0] q;
      wb(1'b0, REG_TUNE, 32'h0, q);
      chk(q, {16'h0000, TUNE_LONG_RST, TUNE_SHORT_RST});
      wb(1'b1, 8'h0c, 32'hffff_ffff, q);
      wb(1'b0, 8'h0c, 32'h0, q);
      chk(q, 32'h0);
      wb(1'b1, REG_TUNE, 32'h0000_0101, q);
      wb(1'b0, REG_TUNE, 32'h0, q);
      chk(q, 32'h0000_0101);
   endtask

   task automatic settle(input logic [24:0] w);
      logic [31:0] q;
      repeat (3) @(posedge clk_i);
      chk(wbits, w[6:4]);
      chk(refresh_in_progress_n_n, 1'b0);
      wb(1'b0, REG_PROG, 32'h0, q);
      chk(q, {7'h00, w});
   endtask

   // Programming only right after reset, flag high, nothing running
   // Order: strobe, select with word, then request
   task automatic cs_prog(input logic [24:0] w);
      int i;
      i = 0;
      @(posedge clk_i);
      ml_n <= 1'b0;
      @(posedge clk_i);
      cs_n <= 1'b0;
      {ecas, bk1, bk0, addr} <= w;
      @(posedge clk_i);
      access_request_n_n <= 1'b0;
      while (transfer_acknowledge_n_n !== 1'b0) step(i);
      chk(wbits, w[6:4]);
      access_request_n_n <= 1'b1;
      while (transfer_acknowledge_n_n !== 1'b1) step(i);
      ml_n <= 1'b1;
      @(posedge clk_i);
      cs_n <= 1'b1;
      settle(w);
   endtask

   task automatic ml_prog(input logic [24:0] w);
      @(posedge clk_i);
      ml_n <= 1'b0;
      @(posedge clk_i);
      {ecas, bk1, bk0, addr} <= w;
      @(posedge clk_i);
      ml_n <= 1'b1;
      settle(w);
   endtask

   task automatic ref_period(input int exp);
      int i;
      i = 0;
      while (dlref !== 1'b0) step(i);
      while (dlref !== 1'b1) step(i);
      i = 0;
      while (dlref !== 1'b0) step(i);
      while (dlref !== 1'b1) step(i);
      chk(i, exp);
   endtask

   task automatic refresh(input int per);
      int i;
      logic [ROW_W-1:0] r;
      i = 0;
      while (ras_n !== 1'b0) step(i);
      r = row;
      i = 0;
      chk(refresh_in_progress_n_n, 1'b0);
      while (ras_n !== 1'b1) step(i);
      chk(i, RAS_LOW_CYC);
      repeat (PRECHARGE_CYC + 2) step(i);
      chk(row, 11'(r + 11'h001));
      chk({cas_n, cas_err}, 2'b10);
      while (ras_n !== 1'b0) step(i);
      chk(i, per);
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      logic [31:0] q;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      do_reset();
      t_regs();
      cs_prog(25'h0400053);
      ref_period(48);
      refresh(48);
      do_reset();
      wb(1'b1, REG_TUNE, 32'h0000_0201, q);
      ml_prog(25'h0800068);
      ref_period(24);
      refresh(48);
      report_and_stop();
   end
endmodule

`default_nettype wire
